//--- core/eic_filt_if.sv
// link between detector front end and glitch filter
`timescale 1ns/100ps
interface eic_filt_if;
    logic [eic_pkg::NLINE-1:0] raw;
    logic [eic_pkg::NLINE-1:0] filtered;
    modport owner (output raw, input filtered);
    modport filt (input raw, output filtered);
endinterface : eic_filt_if

//--- core/eic_glitch_filter.sv
// per-line glitch filter: accepts a change once it has been stable
`timescale 1ns/100ps
module eic_glitch_filter (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // detector side
    eic_filt_if.filt fl
);
    import eic_pkg::*;

    logic [FILT_CNT_W-1:0] stableCnt_reg [NLINE];

    // a change must persist for the whole window before it is accepted
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fl.filtered <= LINE_RST;
            for (int i = 0; i < NLINE; i++) begin
                stableCnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NLINE; i++) begin
                if (fl.raw[i] != fl.filtered[i]) begin
                    if (stableCnt_reg[i] == FILT_LAST) begin
                        fl.filtered[i] <= fl.raw[i];
                        stableCnt_reg[i] <= '0;
                    end else begin
                        stableCnt_reg[i] <= stableCnt_reg[i] + 1'b1;
                    end
                end else begin
                    stableCnt_reg[i] <= '0;
                end
            end
        end
    end

    a_filter_stable: assert property (
        @(posedge core_clk) disable iff (!rstn)
        $changed(fl.filtered[0]) |->
        ($past(fl.raw[0], 1) == fl.filtered[0]) &&
        ($past(fl.raw[0], 2) == fl.filtered[0]) &&
        ($past(fl.raw[0], 3) == fl.filtered[0]))
        else $error("filtered line changed before input was stable");
endmodule : eic_glitch_filter

//--- core/eic_pkg.sv
// constants and types shared by the external interrupt block
package eic_pkg;
    localparam int NLINE = 9;
    localparam int NMI_BIT = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFF_IRQ_EN = 8'h00;
    localparam logic [7:0] OFF_IRQ_DIS = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h0c;
    localparam logic [7:0] OFF_EVT_CLEAR = 8'h10;
    localparam logic [7:0] OFF_TRIG_MODE = 8'h14;
    localparam logic [7:0] OFF_EDGE_POL = 8'h18;
    localparam logic [7:0] OFF_LEVEL_POL = 8'h1c;
    localparam logic [7:0] OFF_GLITCH_SEL = 8'h20;
    localparam logic [7:0] OFF_PAD_OVR = 8'h24;
    localparam logic [7:0] OFF_SYNC_BYPASS = 8'h28;
    localparam logic [7:0] OFF_KEYPAD_CFG = 8'h2c;
    localparam logic [7:0] OFF_LINE_EN = 8'h30;
    localparam logic [7:0] OFF_LINE_DIS = 8'h34;
    localparam logic [7:0] OFF_LINE_VIEW = 8'h38;
    // field positions
    localparam int TEST_EN_BIT = 18;
    localparam int SCAN_EN_BIT = 0;
    localparam int SCAN_RATE_PRESCALE_LSB = 8;
    localparam int SCAN_RATE_PRESCALE_W = 5;
    localparam int PIN_LSB = 24;
    localparam int PIN_W = 3;
    // reset values
    localparam logic [NLINE-1:0] LINE_RST = 9'h000;
    localparam logic [SCAN_RATE_PRESCALE_W-1:0] SCAN_RATE_PRESCALE_RST = 5'h00;
    localparam logic [PIN_W-1:0] PIN_RST = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FILT_STABLE_NS = 300;
    localparam int FILT_STABLE_CYC =
        (FILT_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CNT_W = 3;
    localparam logic [FILT_CNT_W-1:0] FILT_LAST =
        FILT_CNT_W'(FILT_STABLE_CYC - 1);
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN = 2'b10
    } eic_scan_state_t;
endpackage : eic_pkg

//--- core/eic_top.sv
// external interrupt detection, enables, status and keypad scan
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module eic_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register port
    input wire logic [eic_pkg::ADDR_W-1:0] regAddr,
    input wire logic [eic_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [eic_pkg::DATA_W-1:0] regRdata,
    // pads
    input wire logic [eic_pkg::NLINE-1:0] extLinePad,
    input wire logic rcClkPad,
    // outputs
    output logic irqOut,
    output logic [7:0] scanPinSel
);
    import eic_pkg::*;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off,
                                    input logic wr);
        return wr && (a == off);
    endfunction : wr_hit

    function automatic logic [31:0] scan_last(input logic [4:0] p);
        logic [32:0] full;
        // six-bit shift amount, so prescale 31 does not wrap to zero
        full = 33'h0_0000_0001 << ({1'b0, p} + 6'h01);
        return full[31:0] - 32'h0000_0001;
    endfunction : scan_last

    // register file
    logic [NLINE-1:0] irqMask_reg;
    logic [NLINE-1:0] eventStatus_reg;
    logic [NLINE-1:0] trigMode_reg;
    logic [NLINE-1:0] edgePol_reg;
    logic [NLINE-1:0] levelPol_reg;
    logic [NLINE-1:0] glitchSel_reg;
    logic [NLINE-1:0] padOvr_reg;
    logic testModeEnable_reg;
    logic [NLINE-1:0] syncBypass_reg;
    logic [NLINE-1:0] lineEn_reg;
    logic scanEn_reg;
    logic [SCAN_RATE_PRESCALE_W-1:0] scanRatePrescale_reg;
    logic [PIN_W-1:0] scanPin_reg;
    // pad sampling
    logic [NLINE-1:0] padMeta_reg;
    logic [NLINE-1:0] padSync_reg;
    logic [NLINE-1:0] padRsmp_reg;
    logic rcMeta_reg;
    logic rcSync_reg;
    logic rcPrev_reg;
    // detection
    logic [NLINE-1:0] detPrev_reg;
    logic [NLINE-1:0] padPath;
    logic [NLINE-1:0] detIn;
    logic [NLINE-1:0] detVal;
    logic [NLINE-1:0] edgeHit;
    logic [NLINE-1:0] levelHit;
    logic [NLINE-1:0] lineEvent;
    logic [NLINE-1:0] clearMask;
    // scan
    eic_scan_state_t scanState_reg;
    logic [31:0] scanCnt_reg;
    logic rcRise;
    logic scanStep;
    logic [DATA_W-1:0] rdMux;

    eic_filt_if filtLink ();

    eic_glitch_filter uFilter (
        .core_clk(core_clk),
        .rstn(rstn),
        .fl(filtLink.filt)
    );

    // two-flop pad synchronisers, then one resample stage for sync mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            padMeta_reg <= LINE_RST;
            padSync_reg <= LINE_RST;
            padRsmp_reg <= LINE_RST;
        end else begin
            padMeta_reg <= extLinePad;
            padSync_reg <= padMeta_reg;
            padRsmp_reg <= padSync_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rcMeta_reg <= 1'b0;
            rcSync_reg <= 1'b0;
            rcPrev_reg <= 1'b0;
        end else begin
            rcMeta_reg <= rcClkPad;
            rcSync_reg <= rcMeta_reg;
            rcPrev_reg <= rcSync_reg;
        end
    end

    // bypass skips the resample stage; pads always pass two flops first
    assign padPath = (syncBypass_reg & padSync_reg) |
                     (~syncBypass_reg & padRsmp_reg);
    assign detIn = testModeEnable_reg ? padOvr_reg : padPath;
    assign filtLink.raw = detIn;
    assign detVal = (glitchSel_reg & filtLink.filtered) |
                    (~glitchSel_reg & detIn);
    assign edgeHit = (edgePol_reg & detVal & ~detPrev_reg) |
                     (~edgePol_reg & ~detVal & detPrev_reg);
    assign levelHit = ~(detVal ^ levelPol_reg);
    assign lineEvent = lineEn_reg & ((trigMode_reg & levelHit) |
                       (~trigMode_reg & edgeHit));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            detPrev_reg <= LINE_RST;
        end else begin
            detPrev_reg <= detVal;
        end
    end

    // clear through either the clear port or the status offset
    assign clearMask = (wr_hit(regAddr, OFF_EVT_CLEAR, regWr) ||
                        wr_hit(regAddr, OFF_EVT_STATUS, regWr)) ?
                       regWdata[NLINE-1:0] : LINE_RST;

    // a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            eventStatus_reg <= LINE_RST;
        end else begin
            eventStatus_reg <= (eventStatus_reg & ~clearMask) |
                               lineEvent;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqMask_reg <= LINE_RST;
        end else if (wr_hit(regAddr, OFF_IRQ_EN, regWr)) begin
            irqMask_reg <= irqMask_reg | regWdata[NLINE-1:0];
        end else if (wr_hit(regAddr, OFF_IRQ_DIS, regWr)) begin
            irqMask_reg <= irqMask_reg & ~regWdata[NLINE-1:0];
        end
    end

    // nine bits wide: bit 8 is the NMI line, enabled and masked like the other lines
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lineEn_reg <= LINE_RST;
        end else if (wr_hit(regAddr, OFF_LINE_EN, regWr)) begin
            lineEn_reg <= lineEn_reg | regWdata[NLINE-1:0];
        end else if (wr_hit(regAddr, OFF_LINE_DIS, regWr)) begin
            lineEn_reg <= lineEn_reg & ~regWdata[NLINE-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trigMode_reg <= LINE_RST;
            edgePol_reg <= LINE_RST;
            levelPol_reg <= LINE_RST;
            glitchSel_reg <= LINE_RST;
            syncBypass_reg <= LINE_RST;
        end else if (regWr) begin
            case (regAddr)
                OFF_TRIG_MODE: trigMode_reg <= regWdata[NLINE-1:0];
                OFF_EDGE_POL: edgePol_reg <= regWdata[NLINE-1:0];
                OFF_LEVEL_POL: levelPol_reg <= regWdata[NLINE-1:0];
                OFF_GLITCH_SEL: glitchSel_reg <= regWdata[NLINE-1:0];
                OFF_SYNC_BYPASS: syncBypass_reg <= regWdata[NLINE-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            padOvr_reg <= LINE_RST;
            testModeEnable_reg <= 1'b0;
        end else if (wr_hit(regAddr, OFF_PAD_OVR, regWr)) begin
            padOvr_reg <= regWdata[NLINE-1:0];
            testModeEnable_reg <= regWdata[TEST_EN_BIT];
        end
    end

    // pin index has no write path at all
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scanEn_reg <= 1'b0;
            scanRatePrescale_reg <= SCAN_RATE_PRESCALE_RST;
        end else if (wr_hit(regAddr, OFF_KEYPAD_CFG, regWr)) begin
            scanEn_reg <= regWdata[SCAN_EN_BIT];
            scanRatePrescale_reg <= regWdata[SCAN_RATE_PRESCALE_LSB +: SCAN_RATE_PRESCALE_W];
        end
    end

    // keypad scan: rc clock is slow, so its edges are counted here
    assign rcRise = rcSync_reg & ~rcPrev_reg;
    assign scanStep = (scanState_reg == SCAN_RUN) && rcRise &&
                      (scanCnt_reg == scan_last(scanRatePrescale_reg));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scanState_reg <= SCAN_IDLE;
            scanCnt_reg <= 32'h0000_0000;
            scanPin_reg <= PIN_RST;
        end else begin
            case (scanState_reg)
                SCAN_IDLE: begin
                    scanCnt_reg <= 32'h0000_0000;
                    scanPin_reg <= PIN_RST;
                    if (scanEn_reg) begin
                        scanState_reg <= SCAN_RUN;
                    end
                end
                SCAN_RUN: begin
                    if (!scanEn_reg) begin
                        scanState_reg <= SCAN_IDLE;
                    end else if (scanStep) begin
                        scanCnt_reg <= 32'h0000_0000;
                        scanPin_reg <= scanPin_reg + 1'b1;
                    end else if (rcRise) begin
                        scanCnt_reg <= scanCnt_reg + 32'h0000_0001;
                    end
                end
                default: scanState_reg <= SCAN_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scanPinSel <= 8'h00;
        end else if (scanState_reg == SCAN_RUN && scanEn_reg) begin
            scanPinSel <= 8'h01 << scanPin_reg;
        end else begin
            scanPinSel <= 8'h00;
        end
    end

    // one cycle behind status; fine for a level request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(eventStatus_reg & irqMask_reg);
        end
    end

    // read mux; write-only and unmapped offsets read zero
    always_comb begin
        rdMux = RDATA_RST;
        case (regAddr)
            OFF_IRQ_MASK: rdMux[NLINE-1:0] = irqMask_reg;
            OFF_EVT_STATUS: rdMux[NLINE-1:0] = eventStatus_reg;
            OFF_TRIG_MODE: rdMux[NLINE-1:0] = trigMode_reg;
            OFF_EDGE_POL: rdMux[NLINE-1:0] = edgePol_reg;
            OFF_LEVEL_POL: rdMux[NLINE-1:0] = levelPol_reg;
            OFF_GLITCH_SEL: rdMux[NLINE-1:0] = glitchSel_reg;
            OFF_SYNC_BYPASS: rdMux[NLINE-1:0] = syncBypass_reg;
            OFF_PAD_OVR: begin
                rdMux[NLINE-1:0] = padOvr_reg;
                rdMux[TEST_EN_BIT] = testModeEnable_reg;
            end
            OFF_KEYPAD_CFG: begin
                rdMux[SCAN_EN_BIT] = scanEn_reg;
                rdMux[SCAN_RATE_PRESCALE_LSB +: SCAN_RATE_PRESCALE_W] = scanRatePrescale_reg;
                rdMux[PIN_LSB +: PIN_W] = scanPin_reg;
            end
            OFF_LINE_VIEW: rdMux[NLINE-1:0] = lineEn_reg;
            default: rdMux = RDATA_RST;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= RDATA_RST;
        end else if (regRd) begin
            regRdata <= rdMux;
        end else begin
            regRdata <= RDATA_RST;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_edge_event: assert property (
        (lineEn_reg[0] && !trigMode_reg[0] &&
         (detVal[0] != detPrev_reg[0]) && (detVal[0] == edgePol_reg[0]))
        |=> eventStatus_reg[0])
        else $error("selected edge did not set status");

    a_edge_wrong: assert property (
        (!trigMode_reg[0] && !eventStatus_reg[0] &&
         (detVal[0] == detPrev_reg[0] || detVal[0] != edgePol_reg[0]))
        |=> !eventStatus_reg[0])
        else $error("status set without the selected edge");

    a_level_event: assert property (
        (lineEn_reg[1] && trigMode_reg[1] &&
         detVal[1] == levelPol_reg[1]) |=> eventStatus_reg[1])
        else $error("active level did not set status");

    a_filter_bypass: assert property (
        !glitchSel_reg[2] |-> detVal[2] == detIn[2])
        else $error("unfiltered line not taken directly");

    a_test_source: assert property (
        testModeEnable_reg |-> detIn == padOvr_reg)
        else $error("test mode did not feed the override value");

    a_pad_source: assert property (
        !testModeEnable_reg && !syncBypass_reg[NMI_BIT]
        |-> detIn[NMI_BIT] == $past(padSync_reg[NMI_BIT], 1))
        else $error("sync path did not use resampled pad");

    a_bypass_path: assert property (
        syncBypass_reg[3] |-> padPath[3] == padSync_reg[3])
        else $error("bypassed line was resampled");

    a_enable_write: assert property (
        wr_hit(regAddr, OFF_LINE_EN, regWr)
        |=> lineEn_reg == ($past(lineEn_reg) | $past(regWdata[NLINE-1:0])))
        else $error("enable port write wrong");

    a_disable_write: assert property (
        wr_hit(regAddr, OFF_LINE_DIS, regWr)
        |=> lineEn_reg == ($past(lineEn_reg) & ~$past(regWdata[NLINE-1:0])))
        else $error("disable port write wrong");

    a_view_read: assert property (
        regRd && regAddr == OFF_LINE_VIEW
        |=> regRdata[NLINE-1:0] == $past(lineEn_reg))
        else $error("enabled view read wrong");

    a_status_sticky: assert property (
        eventStatus_reg[NMI_BIT] && !clearMask[NMI_BIT]
        |=> eventStatus_reg[NMI_BIT])
        else $error("status flag dropped without a clear");

    a_scan_off: assert property (
        !scanEn_reg [*2] |-> scanPinSel == 8'h00)
        else $error("scan select active while disabled");

    a_scan_step: assert property (
        $changed(scanPin_reg) && scanEn_reg && $past(scanEn_reg)
        |-> $past(rcRise) &&
            $past(scanCnt_reg) == $past(scan_last(scanRatePrescale_reg)))
        else $error("scan pin stepped off the prescaled period");

    a_pin_readonly: assert property (
        wr_hit(regAddr, OFF_KEYPAD_CFG, regWr) && !scanStep &&
        scanState_reg == SCAN_RUN && scanEn_reg |=> $stable(scanPin_reg))
        else $error("pin index moved on a register write");

    c_level_irq: cover property (
        trigMode_reg[0] && lineEvent[0] ##1 eventStatus_reg[0] ##1 irqOut);
    c_test_event: cover property (testModeEnable_reg && |lineEvent);
    c_scan_step: cover property (scanStep ##1 scanPin_reg == 3'h1);
    c_set_and_clear: cover property (|(lineEvent & clearMask));
endmodule : eic_top

//--- test/eic_pad_model.sv
// pad and rc clock model driving the external interrupt pins
`timescale 1ns/100ps
module eic_pad_model (
    // commands from bench
    input wire logic [8:0] padCmd,
    input wire logic rcRun,
    // pins
    output logic [8:0] extLinePad,
    output logic rcClkPad,
    output int rcRises
);
    // pads are always driven, so they simply follow the command
    assign extLinePad = padCmd;
    // rc clock unrelated to core clock, stands still when not run
    initial begin
        rcClkPad = 1'b0;
        rcRises = 0;
        forever begin
            #1370;
            if (rcRun) begin
                rcClkPad = ~rcClkPad;
                if (rcClkPad) rcRises++;
            end
        end
    end
endmodule : eic_pad_model

//--- test/tb_external_interrupt_config.sv
// self-checking bench for the external interrupt block
`timescale 1ns/100ps
module tb_external_interrupt_config;
    import eic_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic [NLINE-1:0] extLinePad;
    logic [NLINE-1:0] padCmd = 9'h100;
    logic rcClkPad;
    logic rcRun = 1'b0;
    logic irqOut;
    logic [7:0] scanPinSel;
    int rcRises;
    int err_count = 0;
    int n_checks = 0;
    int r0;
    int r1;
    logic [7:0] rstOff [13] = '{OFF_IRQ_EN, OFF_IRQ_DIS, OFF_IRQ_MASK,
        OFF_EVT_STATUS, OFF_EVT_CLEAR, OFF_TRIG_MODE, OFF_EDGE_POL,
        OFF_LEVEL_POL, OFF_GLITCH_SEL, OFF_PAD_OVR, OFF_SYNC_BYPASS,
        OFF_KEYPAD_CFG, OFF_LINE_VIEW};
    logic [7:0] rwOff [3] = '{OFF_LEVEL_POL, OFF_GLITCH_SEL, OFF_SYNC_BYPASS};

    always #50 core_clk = ~core_clk;

    eic_top i_dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .extLinePad(extLinePad), .rcClkPad(rcClkPad),
        .irqOut(irqOut), .scanPinSel(scanPinSel));
    eic_pad_model i_pads (.padCmd(padCmd), .rcRun(rcRun),
        .extLinePad(extLinePad), .rcClkPad(rcClkPad), .rcRises(rcRises));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chkVal(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chkVal

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chkVal($sformatf("reg %h", a), e, regRdata);
    endtask : chkReg

    // cycles from pad change to interrupt output
    task automatic lat(input logic [8:0] p0, input logic [8:0] p1,
        input logic [31:0] byp, input logic [31:0] flt, input int e);
        int n;
        @(posedge core_clk);
        padCmd <= p0;
        wr(OFF_SYNC_BYPASS, byp);
        wr(OFF_GLITCH_SEL, flt);
        repeat (12) @(posedge core_clk);
        wr(OFF_EVT_CLEAR, 32'h0000_01ff);
        repeat (3) @(posedge core_clk);
        n = 0;
        padCmd <= p1;
        while (irqOut !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chkVal("irq latency", 32'(e), 32'(n));
    endtask : lat

    // two-cycle pulse on line 1
    task automatic glitch(input logic [31:0] flt, input logic [31:0] e);
        wr(OFF_GLITCH_SEL, flt);
        repeat (12) @(posedge core_clk);
        wr(OFF_EVT_CLEAR, 32'h0000_01ff);
        @(posedge core_clk);
        padCmd <= 9'h002;
        repeat (2) @(posedge core_clk);
        padCmd <= 9'h000;
        repeat (12) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, e);
    endtask : glitch

    task automatic waitStep(output int r);
        logic [7:0] s;
        int n;
        s = scanPinSel;
        n = 0;
        while (scanPinSel === s && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            err_count++;
            report_and_stop();
        end
        r = rcRises;
    endtask : waitStep

    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        foreach (rstOff[i]) chkReg(rstOff[i], 32'h0000_0000);
        chkReg(8'h3c, 32'h0000_0000);
        chkVal("scanPinSel", 32'h0, 32'(scanPinSel));
        foreach (rwOff[i]) begin
            wr(rwOff[i], 32'hffff_ffff);
            chkReg(rwOff[i], 32'h0000_01ff);
            wr(rwOff[i], 32'h0000_0000);
        end
        wr(OFF_LINE_EN, 32'h0000_0101);
        chkReg(OFF_LINE_VIEW, 32'h0000_0101);
        wr(OFF_LINE_EN, 32'h0000_0000);
        chkReg(OFF_LINE_VIEW, 32'h0000_0101);
        wr(OFF_LINE_DIS, 32'h0000_0001);
        chkReg(OFF_LINE_VIEW, 32'h0000_0100);
        wr(OFF_LINE_DIS, 32'h0000_0100);
        chkReg(OFF_LINE_VIEW, 32'h0000_0000);
        wr(OFF_LINE_EN, 32'h0000_01ff);
        wr(OFF_IRQ_EN, 32'h0000_01ff);
        wr(OFF_EDGE_POL, 32'h0000_00ff);
        repeat (8) @(posedge core_clk);
        wr(OFF_EVT_CLEAR, 32'h0000_01ff);
        chkReg(OFF_EVT_STATUS, 32'h0000_0000);
        padCmd <= 9'h0ff;
        repeat (8) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_01ff);
        chkVal("irqOut", 32'h1, 32'(irqOut));
        wr(OFF_IRQ_DIS, 32'h0000_01ff);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chkVal("irqOut", 32'h0, 32'(irqOut));
        wr(OFF_EVT_CLEAR, 32'h0000_000f);
        chkReg(OFF_EVT_STATUS, 32'h0000_01f0);
        wr(OFF_EVT_CLEAR, 32'h0000_01f0);
        padCmd <= 9'h100;
        repeat (8) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_0000);
        wr(OFF_IRQ_EN, 32'h0000_01ff);
        wr(OFF_LEVEL_POL, 32'h0000_000f);
        wr(OFF_TRIG_MODE, 32'h0000_01ff);
        repeat (8) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_00f0);
        padCmd <= 9'h00f;
        wr(OFF_EVT_CLEAR, 32'h0000_01ff);
        repeat (8) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_01ff);
        padCmd <= 9'h1f0;
        repeat (8) @(posedge core_clk);
        wr(OFF_EVT_CLEAR, 32'h0000_01ff);
        repeat (3) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_0000);
        wr(OFF_TRIG_MODE, 32'h0000_0000);
        lat(9'h000, 9'h001, 32'h0000_01ff, 32'h0000_0000, 4);
        lat(9'h000, 9'h001, 32'h0000_0000, 32'h0000_0000, 5);
        lat(9'h100, 9'h000, 32'h0000_0100, 32'h0000_0000, 4);
        lat(9'h100, 9'h000, 32'h0000_0000, 32'h0000_0000, 5);
        lat(9'h000, 9'h001, 32'h0000_01ff, 32'h0000_01ff, 7);
        glitch(32'h0000_01ff, 32'h0000_0000);
        glitch(32'h0000_0000, 32'h0000_0002);
        wr(OFF_PAD_OVR, 32'h0004_0000);
        wr(OFF_EVT_CLEAR, 32'h0000_01ff);
        wr(OFF_PAD_OVR, 32'h0004_0001);
        padCmd <= 9'h002;
        repeat (8) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_0001);
        chkReg(OFF_PAD_OVR, 32'h0004_0001);
        wr(OFF_PAD_OVR, 32'h0000_0000);
        repeat (8) @(posedge core_clk);
        chkReg(OFF_EVT_STATUS, 32'h0000_0003);
        rcRun <= 1'b1;
        wr(OFF_KEYPAD_CFG, 32'h0000_0101);
        waitStep(r0);
        chkVal("scanPinSel", 32'h1, 32'(scanPinSel));
        waitStep(r0);
        waitStep(r1);
        chkVal("scanPinSel", 32'h4, 32'(scanPinSel));
        chkVal("rc rises per step", 32'h4, 32'(r1 - r0));
        chkReg(OFF_KEYPAD_CFG, 32'h0200_0101);
        wr(OFF_KEYPAD_CFG, 32'h0700_0101);
        chkReg(OFF_KEYPAD_CFG, 32'h0200_0101);
        wr(OFF_KEYPAD_CFG, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chkVal("scanPinSel", 32'h0, 32'(scanPinSel));
        chkReg(OFF_KEYPAD_CFG, 32'h0000_0000);
        wr(OFF_KEYPAD_CFG, 32'h0000_0001);
        waitStep(r0);
        waitStep(r0);
        waitStep(r1);
        chkVal("rc rises per step", 32'h2, 32'(r1 - r0));
        rcRun <= 1'b0;
        report_and_stop();
    end
endmodule : tb_external_interrupt_config
